/* File: logic/rtc_pkg.sv */
package rtc_pkg;

	// Widths
	localparam int ACC_W   = 67;
	localparam int INC_W   = 32;
	localparam int VIEW_W  = 32;

	// Slice positions of the accumulator
	localparam int FINE_LSB   = 19;
	localparam int COARSE_LSB = 35;
	localparam int US_LSB     = 16;
	localparam int QUS_LSB    = 14;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_INC    = 8'h04;
	localparam logic [7:0] OFF_FINE   = 8'h08;
	localparam logic [7:0] OFF_COARSE = 8'h0c;
	localparam logic [7:0] OFF_CMP    = 8'h10;
	localparam logic [7:0] OFF_CAPT   = 8'h14;
	localparam logic [7:0] OFF_STAT   = 8'h18;
	localparam logic [7:0] OFF_MASK   = 8'h1c;

	// Field positions
	localparam int CTRL_WAKE_BIT = 0;
	localparam int EV_CMP_BIT    = 0;
	localparam int EV_CAP_BIT    = 1;
	localparam int EV_W          = 2;

	// Reset values
	localparam logic [31:0] RST_INC  = 32'h001e8480;
	localparam logic [31:0] RST_CTRL = 32'h00000000;
	localparam logic [31:0] RST_CMP  = 32'h00000000;
	localparam logic [1:0]  RST_MASK = 2'h0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: logic/rtc_chan_if.sv */
`timescale 1ns/1ps
interface rtc_chan_if;
	logic        clr;
	logic [31:0] now;
	logic [31:0] cmp_val;
	logic        cmp_load;
	logic        cmp_hit;
	logic        trig;
	logic [31:0] cap_val;
	logic        cap_hit;

	modport ctl (output clr, now, cmp_val, cmp_load, trig,
		input cmp_hit, cap_val, cap_hit);
	modport ch (input clr, now, cmp_val, cmp_load, trig,
		output cmp_hit, cap_val, cap_hit);
endinterface

/* File: logic/rtc_channel.sv */
`timescale 1ns/1ps
module rtc_channel (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic ce,
	rtc_chan_if.ch    ch
);

	logic        armed_q;
	logic        hit_q;
	logic        caphit_q;
	logic [31:0] cap_q;
	logic [31:0] diff;
	logic        reached;

	////////////////////////////////////////////////////////////////////////
	// Compare reach and capture latch

	assign diff    = ch.now - ch.cmp_val;
	assign reached = ~diff[31];

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			armed_q  <= 1'b0;
			hit_q    <= 1'b0;
			caphit_q <= 1'b0;
			cap_q    <= 32'h0;
		end
		else if (ce)
		begin
			if (ch.clr)
			begin
				armed_q  <= 1'b0;
				hit_q    <= 1'b0;
				caphit_q <= 1'b0;
				cap_q    <= 32'h0;
			end
			else
			begin
				armed_q  <= ch.cmp_load | (armed_q & ~reached);
				hit_q    <= armed_q & reached & ~ch.cmp_load;
				caphit_q <= ch.trig;
				if (ch.trig)
				begin
					cap_q <= ch.now;
				end
			end
		end
	end

	assign ch.cmp_hit = hit_q;
	assign ch.cap_hit = caphit_q;
	assign ch.cap_val = cap_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_cmp_fire_once: assert property (
		ce && armed_q && reached && !ch.cmp_load && !ch.clr
		|=> ch.cmp_hit && !armed_q)
		else $error("compare did not fire once when reached");

	a_cap_latch_now: assert property (
		ce && ch.trig && !ch.clr
		|=> ch.cap_val == $past(ch.now) && ch.cap_hit)
		else $error("capture did not latch the fine time");

endmodule

/* File: logic/rtc_core.sv */
`timescale 1ns/1ps
module rtc_core #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLK,
	input  wire logic              NRST,
	input  wire logic              CE,
	input  wire logic              LOW_FREQ_CLOCK,
	input  wire logic              CAPT_TRIG,
	input  wire logic              SHUTDOWN,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	output logic                   SYNC_STROBE,
	output logic [31:0]            SYNC_US,
	output logic [31:0]            SYNC_QUS,
	output logic                   WAKE_REQ,
	output logic                   IRQ
);

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
		begin
			merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	localparam int AW = rtc_pkg::ACC_W;

	logic [1:0]        s1_q;
	logic [1:0]        s2_q;
	logic [1:0]        s3_q;
	logic [1:0]        lvl_q;
	logic [1:0]        rise;
	logic              tick;
	logic [AW-1:0]     acc_q;
	logic [AW-1:0]     acc_d;
	logic [31:0]       inc_q;
	logic [31:0]       ctrl_q;
	logic [31:0]       cmp_q;
	logic [1:0]        st_q;
	logic [1:0]        st_d;
	logic [1:0]        mk_q;
	logic [1:0]        ev;
	logic [1:0]        st_clr;
	logic              aw_v_q;
	logic              w_v_q;
	logic [ADDR_W-1:0] aw_a_q;
	logic [31:0]       w_d_q;
	logic [3:0]        w_s_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic              sync_stb_q;
	logic [31:0]       sync_us_q;
	logic [31:0]       sync_qus_q;
	logic              wr_go;
	logic              ar_go;
	logic              wr_ok;
	logic              rd_ok;
	logic [31:0]       rd_val;
	logic [31:0]       fine_w;
	logic [31:0]       coarse_w;

	rtc_chan_if chan ();

	rtc_channel u_chan (
		.clk  (CLK),
		.nrst (NRST),
		.ce   (CE),
		.ch   (chan.ch)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, rising edges once stages two and three agree

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			s1_q  <= 2'h0;
			s2_q  <= 2'h0;
			s3_q  <= 2'h0;
			lvl_q <= 2'h0;
		end
		else if (CE)
		begin
			s1_q <= {CAPT_TRIG, LOW_FREQ_CLOCK};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 2; i++)
			begin
				if (s2_q[i] == s3_q[i])
				begin
					lvl_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign rise = s2_q & s3_q & ~lvl_q;
	assign tick = rise[0];

	////////////////////////////////////////////////////////////////////////
	// Time accumulator

	assign acc_d = SHUTDOWN ? {AW{1'b0}}
		: tick ? acc_q + {{(AW - rtc_pkg::INC_W){1'b0}}, inc_q}
		: acc_q;

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			acc_q      <= {AW{1'b0}};
			sync_stb_q <= 1'b0;
			sync_us_q  <= 32'h0;
			sync_qus_q <= 32'h0;
		end
		else if (CE)
		begin
			acc_q      <= acc_d;
			sync_stb_q <= tick;
			sync_us_q  <= acc_d[rtc_pkg::US_LSB +: 32];
			sync_qus_q <= acc_d[rtc_pkg::QUS_LSB +: 32];
		end
	end

	assign fine_w   = acc_q[rtc_pkg::FINE_LSB +: 32];
	assign coarse_w = acc_q[rtc_pkg::COARSE_LSB +: 32];

	assign SYNC_STROBE = sync_stb_q;
	assign SYNC_US     = sync_us_q;
	assign SYNC_QUS    = sync_qus_q;

	////////////////////////////////////////////////////////////////////////
	// Channel hookup and events

	assign chan.clr      = SHUTDOWN;
	assign chan.now      = fine_w;
	assign chan.cmp_val  = cmp_q;
	assign chan.cmp_load = wr_go & hit(aw_a_q, rtc_pkg::OFF_CMP);
	assign chan.trig     = rise[1];

	assign ev = {chan.cap_hit, chan.cmp_hit};
	assign st_clr = (wr_go & hit(aw_a_q, rtc_pkg::OFF_STAT) & w_s_q[0])
		? w_d_q[1:0] : 2'h0;
	assign st_d = (st_q & ~st_clr) | ev;

	assign IRQ      = |(st_q & mk_q);
	assign WAKE_REQ = ctrl_q[rtc_pkg::CTRL_WAKE_BIT]
		& st_q[rtc_pkg::EV_CMP_BIT];

	////////////////////////////////////////////////////////////////////////
	// Bus slave

	assign AWREADY = CE & ~aw_v_q;
	assign WREADY  = CE & ~w_v_q;
	assign ARREADY = CE & ~rvalid_q;
	assign wr_go   = CE & aw_v_q & w_v_q & ~bvalid_q;
	assign ar_go   = ARVALID & ARREADY;

	assign wr_ok = hit(aw_a_q, rtc_pkg::OFF_CTRL)
		| hit(aw_a_q, rtc_pkg::OFF_INC) | hit(aw_a_q, rtc_pkg::OFF_CMP)
		| hit(aw_a_q, rtc_pkg::OFF_STAT) | hit(aw_a_q, rtc_pkg::OFF_MASK)
		| hit(aw_a_q, rtc_pkg::OFF_FINE) | hit(aw_a_q, rtc_pkg::OFF_COARSE)
		| hit(aw_a_q, rtc_pkg::OFF_CAPT);

	assign rd_ok = hit(ARADDR, rtc_pkg::OFF_CTRL)
		| hit(ARADDR, rtc_pkg::OFF_INC) | hit(ARADDR, rtc_pkg::OFF_CMP)
		| hit(ARADDR, rtc_pkg::OFF_STAT) | hit(ARADDR, rtc_pkg::OFF_MASK)
		| hit(ARADDR, rtc_pkg::OFF_FINE) | hit(ARADDR, rtc_pkg::OFF_COARSE)
		| hit(ARADDR, rtc_pkg::OFF_CAPT);

	assign rd_val =
		hit(ARADDR, rtc_pkg::OFF_CTRL)   ? ctrl_q :
		hit(ARADDR, rtc_pkg::OFF_INC)    ? inc_q :
		hit(ARADDR, rtc_pkg::OFF_FINE)   ? fine_w :
		hit(ARADDR, rtc_pkg::OFF_COARSE) ? coarse_w :
		hit(ARADDR, rtc_pkg::OFF_CMP)    ? cmp_q :
		hit(ARADDR, rtc_pkg::OFF_CAPT)   ? chan.cap_val :
		hit(ARADDR, rtc_pkg::OFF_STAT)   ? {30'h0, st_q} :
		hit(ARADDR, rtc_pkg::OFF_MASK)   ? {30'h0, mk_q} : 32'h0;

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			aw_v_q   <= 1'b0;
			w_v_q    <= 1'b0;
			aw_a_q   <= '0;
			w_d_q    <= 32'h0;
			w_s_q    <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= rtc_pkg::RESP_OKAY;
		end
		else if (CE)
		begin
			if (AWVALID && AWREADY)
			begin
				aw_v_q <= 1'b1;
				aw_a_q <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_v_q <= 1'b1;
				w_d_q <= WDATA;
				w_s_q <= WSTRB;
			end
			if (wr_go)
			begin
				aw_v_q   <= 1'b0;
				w_v_q    <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
			end
			else if (BREADY)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= rtc_pkg::RESP_OKAY;
			rdata_q  <= 32'h0;
		end
		else if (CE)
		begin
			if (ar_go)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_val;
				rresp_q  <= rd_ok ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
			end
			else if (RREADY)
			begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign BVALID = bvalid_q;
	assign BRESP  = bresp_q;
	assign RVALID = rvalid_q;
	assign RRESP  = rresp_q;
	assign RDATA  = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Register file

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ctrl_q <= rtc_pkg::RST_CTRL;
			inc_q  <= rtc_pkg::RST_INC;
			cmp_q  <= rtc_pkg::RST_CMP;
			mk_q   <= rtc_pkg::RST_MASK;
			st_q   <= 2'h0;
		end
		else if (CE)
		begin
			st_q <= SHUTDOWN ? 2'h0 : st_d;
			if (wr_go && hit(aw_a_q, rtc_pkg::OFF_CTRL))
			begin
				ctrl_q <= merge(ctrl_q, w_d_q, w_s_q) & 32'h1;
			end
			if (wr_go && hit(aw_a_q, rtc_pkg::OFF_INC))
			begin
				inc_q <= merge(inc_q, w_d_q, w_s_q);
			end
			if (wr_go && hit(aw_a_q, rtc_pkg::OFF_CMP))
			begin
				cmp_q <= merge(cmp_q, w_d_q, w_s_q);
			end
			if (wr_go && hit(aw_a_q, rtc_pkg::OFF_MASK) && w_s_q[0])
			begin
				mk_q <= w_d_q[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	sequence s_fine_ask;
		ar_go && CE && hit(ARADDR, rtc_pkg::OFF_FINE);
	endsequence

	sequence s_coarse_ask;
		ar_go && CE && hit(ARADDR, rtc_pkg::OFF_COARSE);
	endsequence

	a_acc_tick_add: assert property (
		CE && tick && !SHUTDOWN
		|=> acc_q == $past(acc_q) + {35'h0, $past(inc_q)})
		else $error("accumulator did not add the increment");

	a_acc_idle_hold: assert property (
		CE && !tick && !SHUTDOWN |=> $stable(acc_q))
		else $error("accumulator moved without a slow edge");

	a_shutdown_clear: assert property (
		CE && SHUTDOWN |=> acc_q == '0 && st_q == 2'h0)
		else $error("shutdown did not clear the state");

	a_fine_read_view: assert property (
		s_fine_ask |=> RVALID && RDATA == $past(fine_w))
		else $error("fine view read returned wrong bits");

	a_coarse_read_view: assert property (
		s_coarse_ask |=> RVALID && RDATA == $past(coarse_w))
		else $error("coarse view read returned wrong bits");

	a_sync_time_base: assert property (
		CE && tick |=> SYNC_STROBE && SYNC_US == acc_q[47:16])
		else $error("sync output not aligned to accumulator");

	a_sync_units_tie: assert property (
		SYNC_STROBE |-> SYNC_QUS[31:2] == SYNC_US[29:0])
		else $error("quarter microsecond view disagrees");

	a_wake_raise: assert property (
		CE && chan.cmp_hit && ctrl_q[0] && !SHUTDOWN |=> WAKE_REQ)
		else $error("compare event gave no wake request");

endmodule

/* File: verification/sys_timer_model.sv */
`timescale 1ns/1ps
// Slow clock source and system timer end of the sync path
module sys_timer_model #(
	parameter int HALF = 20
) (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic sync_strobe,
	output logic      slow_clk,
	output int        ticks
);
	int   cnt   = 0;
	int   seen  = 0;
	logic level = 1'b0;

	assign slow_clk = level;
	assign ticks    = seen;

	// Slow clock, parked low between runs
	always @(posedge clk)
	begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1 && (run || level))
			level <= ~level;
	end

	// Counts time base updates taken by the timer
	always @(posedge clk)
	begin
		if (sync_strobe)
			seen <= seen + 1;
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        CLK, NRST, CE, CAPT_TRIG, SHUTDOWN, LOW_FREQ_CLOCK;
	logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY, SYNC_STROBE;
	logic        WAKE_REQ, IRQ, run;
	logic [7:0]  AWADDR, ARADDR;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, rsp;
	logic [31:0] WDATA, RDATA, SYNC_US, SYNC_QUS, rd, inc;
	logic [66:0] acc;
	int          miscompares, check_count, ticks, tprev, i;

	rtc_core #(.ADDR_W(8)) i_rtc_core (
		.CLK(CLK), .NRST(NRST), .CE(CE), .LOW_FREQ_CLOCK(LOW_FREQ_CLOCK),
		.CAPT_TRIG(CAPT_TRIG), .SHUTDOWN(SHUTDOWN), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .SYNC_STROBE(SYNC_STROBE), .SYNC_US(SYNC_US),
		.SYNC_QUS(SYNC_QUS), .WAKE_REQ(WAKE_REQ), .IRQ(IRQ));

	sys_timer_model #(.HALF(20)) timer_side (.clk(CLK), .run(run),
		.sync_strobe(SYNC_STROBE), .slow_clk(LOW_FREQ_CLOCK), .ticks(ticks));

	initial
	begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk32(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		chk32(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic tmo();
		miscompares++;
		$display("CHECK FAILED wait expected done seen timeout");
		end_sim();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		AWADDR  <= a;
		WDATA   <= d;
		WSTRB   <= 4'hf;
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID)
				break;
		end
		if (n == 50)
			tmo();
		rsp = BRESP;
		BREADY <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		int n;
		@(posedge CLK);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID)
				break;
		end
		if (n == 50)
			tmo();
		rd = RDATA;
		rsp = RRESP;
		RREADY <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		axr(a);
		chk32(nm, e, rd);
	endtask

	// Runs the slow clock until a count of ticks or an event
	task automatic slow_run(input int n, input bit to_wake);
		int k;
		tprev = ticks;
		run <= 1'b1;
		for (k = 0; k < 5000; k++)
		begin
			@(posedge CLK);
			if (to_wake ? WAKE_REQ : ticks >= tprev + n)
				break;
		end
		if (k == 5000)
			tmo();
		chk32("ticks", 32'(n), 32'(ticks - tprev));
		run <= 1'b0;
		repeat (60) @(posedge CLK);
		acc = acc + 67'(inc) * 67'(ticks - tprev);
	endtask

	task automatic chk_time();
		rchk("fine", rtc_pkg::OFF_FINE, acc[50:19]);
		rchk("coarse", rtc_pkg::OFF_COARSE, acc[66:35]);
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		{NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{CAPT_TRIG, SHUTDOWN, run, AWADDR, ARADDR, WDATA} = '0;
		CE = 1'b1;
		WSTRB = 4'hf;
		miscompares = 0;
		check_count = 0;
		acc = '0;
		inc = rtc_pkg::RST_INC;
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		rchk("ctrl", rtc_pkg::OFF_CTRL, rtc_pkg::RST_CTRL);
		chk32("rresp", rtc_pkg::RESP_OKAY, rsp);
		rchk("inc", rtc_pkg::OFF_INC, rtc_pkg::RST_INC);
		rchk("cmp", rtc_pkg::OFF_CMP, rtc_pkg::RST_CMP);
		rchk("stat", rtc_pkg::OFF_STAT, 32'h0);
		rchk("mask", rtc_pkg::OFF_MASK, {30'h0, rtc_pkg::RST_MASK});
		chk_time();
		rchk("unmapped", 8'h20, 32'h0);
		chk32("rresp", rtc_pkg::RESP_SLVERR, rsp);
		axw(8'h24, 32'h1);
		chk32("bresp", rtc_pkg::RESP_SLVERR, rsp);
		slow_run(4, 1'b0);
		chk_time();
		CE <= 1'b0;
		run <= 1'b1;
		tprev = ticks;
		repeat (50) @(posedge CLK);
		chkb("awready", 1'b0, AWREADY);
		chkb("arready", 1'b0, ARREADY);
		run <= 1'b0;
		repeat (40) @(posedge CLK);
		CE <= 1'b1;
		chk32("frozen", 32'(tprev), 32'(ticks));
		chk_time();
		inc = 32'hffffffff;
		axw(rtc_pkg::OFF_INC, inc);
		slow_run(10, 1'b0);
		chk_time();
		chk32("sync_us", acc[47:16], SYNC_US);
		chk32("sync_qus", acc[45:14], SYNC_QUS);
		SHUTDOWN <= 1'b1;
		@(posedge CLK);
		SHUTDOWN <= 1'b0;
		acc = '0;
		chk_time();
		inc = 32'h00080000;
		axw(rtc_pkg::OFF_INC, inc);
		axw(rtc_pkg::OFF_CTRL, 32'h1);
		axw(rtc_pkg::OFF_MASK, 32'h1);
		axw(rtc_pkg::OFF_CMP, 32'h3);
		rchk("stat", rtc_pkg::OFF_STAT, 32'h0);
		chkb("wake", 1'b0, WAKE_REQ);
		slow_run(3, 1'b1);
		chkb("irq", 1'b1, IRQ);
		rchk("stat", rtc_pkg::OFF_STAT, 32'h1);
		chk_time();
		axw(rtc_pkg::OFF_CTRL, 32'h0);
		chkb("wake", 1'b0, WAKE_REQ);
		axw(rtc_pkg::OFF_CTRL, 32'h1);
		chkb("wake", 1'b1, WAKE_REQ);
		axw(rtc_pkg::OFF_STAT, 32'h1);
		chkb("wake", 1'b0, WAKE_REQ);
		chkb("irq", 1'b0, IRQ);
		axw(rtc_pkg::OFF_MASK, 32'h3);
		CAPT_TRIG <= 1'b1;
		for (i = 0; i < 50 && !IRQ; i++)
			@(posedge CLK);
		if (i == 50)
			tmo();
		CAPT_TRIG <= 1'b0;
		rchk("capt", rtc_pkg::OFF_CAPT, acc[50:19]);
		rchk("stat", rtc_pkg::OFF_STAT, 32'h2);
		axw(rtc_pkg::OFF_CAPT, 32'h0);
		chk32("bresp", rtc_pkg::RESP_OKAY, rsp);
		rchk("capt", rtc_pkg::OFF_CAPT, acc[50:19]);
		axw(rtc_pkg::OFF_MASK, 32'h1);
		chkb("irq", 1'b0, IRQ);
		axw(rtc_pkg::OFF_STAT, 32'h2);
		rchk("stat", rtc_pkg::OFF_STAT, 32'h0);
		NRST <= 1'b0;
		@(posedge CLK);
		NRST <= 1'b1;
		acc = '0;
		chk_time();
		rchk("inc", rtc_pkg::OFF_INC, rtc_pkg::RST_INC);
		end_sim();
	end
endmodule
